// ==== hdl/dcsp_cfg.svh ====
// Register offsets, reset values, field positions and timing constants
`ifndef DCSP_CFG_SVH
`define DCSP_CFG_SVH
`define DCSP_RA_DISP_MODE   8'h02
`define DCSP_RA_LOOP_SEL    8'h0C
`define DCSP_RA_CATH_LVL    8'h0D
`define DCSP_RA_PWR_DOWN    8'h0E
`define DCSP_RA_FAULT_CTL   8'h1E
`define DCSP_RA_FAULT_FLG   8'h1F
`define DCSP_RST_DISP_MODE  8'h20
`define DCSP_RST_LOOP_SEL   2'h0
`define DCSP_RST_CATH_LVL   8'h80
`define DCSP_RST_PWR_DOWN   8'h00
`define DCSP_RST_FAULT_CTL  8'h00
`define DCSP_BIT_BLANK      5
`define DCSP_BIT_FC_BLANK   7
`define DCSP_BIT_SLEEP      0
`define DCSP_SLAVE_BASE     6'h17
`define DCSP_FLAG_PERIOD_MS 100
`define DCSP_SYS_CLK_KHZ    250000
`endif

// ==== hdl/dcsp_pkg.sv ====
// Types shared by the display control serial port
package dcsp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACK  = 3'h2,
        ST_RX   = 3'h3,
        ST_TX   = 3'h4,
        ST_MACK = 3'h5
    } dcsp_state_e;
    typedef struct packed {
        logic [7:0] target;
        logic       manual;
        logic       dimming;
    } dcsp_cathode_s;
endpackage

// ==== hdl/dcsp_top.sv ====
// Display control: two-wire register slave, fault report, cathode loop, power control
`include "dcsp_cfg.svh"
module dcsp_top #(
    parameter int unsigned P_FLAG_CYC     = `DCSP_FLAG_PERIOD_MS * `DCSP_SYS_CLK_KHZ,
    parameter logic [7:0]  P_CATH_LVL_RST = `DCSP_RST_CATH_LVL
) (
    // System
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset,
    // Serial pins
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_sda,
    output logic                       o_sda_oe,
    input  wire logic                  i_addr_select_pin,
    // Fault detection
    input  wire logic [5:0]            i_fault_raw,
    output logic                       o_fault,
    output logic                       o_array_black,
    // Cathode loop
    input  wire logic [7:0]            i_auto_target,
    output dcsp_pkg::dcsp_cathode_s    o_cathode,
    // Power
    output logic                       o_sleep,
    output logic [6:0]                 o_block_off
);
    localparam int CW = $clog2(P_FLAG_CYC);

    generate
        if (P_FLAG_CYC < 2) begin : g_chk
            $error("P_FLAG_CYC must be at least 2");
        end
    endgenerate

    // ****************************************
    // Declarations
    // ****************************************
    logic [1:0]             scl_q;
    logic [1:0]             sda_q;
    logic [1:0]             sel_q;
    logic                   scl_d;
    logic                   sda_d;
    logic [5:0]             flt_q1;
    logic [5:0]             flt_q2;
    logic [CW-1:0]          tick_cnt;
    logic [CW-1:0]          next_tick_cnt;
    logic [5:0]             flt_acc;
    logic [5:0]             next_flt_acc;
    logic [7:0]             fault_flags;
    logic [7:0]             next_fault_flags;
    logic                   fault_blank;
    logic                   next_fault_blank;
    logic                   next_fault;
    logic                   next_black;
    dcsp_pkg::dcsp_cathode_s next_cathode;
    logic [6:0]             next_block_off;
    logic [5:0]             flt_live;
    logic                   tick;
    dcsp_pkg::dcsp_state_e  st;
    dcsp_pkg::dcsp_state_e  next_st;
    logic [3:0]             cnt;
    logic [3:0]             next_cnt;
    logic [7:0]             shr;
    logic [7:0]             next_shr;
    logic [7:0]             ptr;
    logic [7:0]             next_ptr;
    logic                   have_ptr;
    logic                   next_have_ptr;
    logic                   rd;
    logic                   next_rd;
    logic                   nack;
    logic                   next_nack;
    logic                   sda_low;
    logic                   next_sda_low;
    logic [7:0]             display_mode_reg;
    logic [7:0]             next_display_mode_reg;
    logic [1:0]             cathode_loop_select;
    logic [1:0]             next_cathode_loop_select;
    logic [7:0]             cathode_level;
    logic [7:0]             next_cathode_level;
    logic [7:0]             power_down_ctrl;
    logic [7:0]             next_power_down_ctrl;
    logic [7:0]             fault_control;
    logic [7:0]             next_fault_control;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start;
    logic                   stop;
    logic [7:0]             rdata;

    function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [7:0] dm,
                                          input logic [1:0] ls, input logic [7:0] cl,
                                          input logic [7:0] pd, input logic [7:0] fc,
                                          input logic [7:0] ff);
        case (a)
            `DCSP_RA_DISP_MODE: rd_reg = dm;
            `DCSP_RA_LOOP_SEL:  rd_reg = {6'h00, ls};
            `DCSP_RA_CATH_LVL:  rd_reg = cl;
            `DCSP_RA_PWR_DOWN:  rd_reg = pd;
            `DCSP_RA_FAULT_CTL: rd_reg = fc;
            `DCSP_RA_FAULT_FLG: rd_reg = ff;
            default:            rd_reg = 8'h00;
        endcase
    endfunction

    // ****************************************
    // Fault, display and power control
    // ****************************************
    always_comb begin
        flt_live         = flt_q2 & fault_control[5:0];
        tick             = (tick_cnt == CW'(P_FLAG_CYC - 1));
        next_tick_cnt    = tick ? '0 : tick_cnt + 1'b1;
        next_flt_acc     = tick ? flt_live : (flt_acc | flt_live);
        next_fault_flags = tick ? {2'h0, flt_acc | flt_live} : fault_flags;
        next_fault_blank = fault_control[`DCSP_BIT_FC_BLANK]
                           & (fault_blank | (|flt_live));
        next_fault       = |flt_live;
        next_black       = display_mode_reg[`DCSP_BIT_BLANK] | next_fault_blank;
        next_cathode     = '{target: i_auto_target, manual: 1'b0, dimming: 1'b1};
        unique case (cathode_loop_select)
            2'h1: begin
                if (i_auto_target < cathode_level) begin
                    next_cathode.target = cathode_level;
                    next_cathode.manual = 1'b1;
                end
            end
            2'h2: next_cathode = '{target: cathode_level, manual: 1'b1, dimming: 1'b0};
            default: ;
        endcase
        next_block_off = power_down_ctrl[`DCSP_BIT_SLEEP] ? 7'h7F
                         : power_down_ctrl[7:1];
    end

    always_ff @(posedge i_clk_sys) begin
        flt_q1 <= i_fault_raw;
        flt_q2 <= flt_q1;
        if (i_reset) begin
            tick_cnt      <= '0;
            flt_acc       <= 6'h00;
            fault_flags   <= 8'h00;
            fault_blank   <= 1'b0;
            o_fault       <= 1'b0;
            o_array_black <= 1'b1;
            o_cathode     <= '0;
            o_sleep       <= 1'b0;
            o_block_off   <= 7'h00;
        end else begin
            tick_cnt      <= next_tick_cnt;
            flt_acc       <= next_flt_acc;
            fault_flags   <= next_fault_flags;
            fault_blank   <= next_fault_blank;
            o_fault       <= next_fault;
            o_array_black <= next_black;
            o_cathode     <= next_cathode;
            o_sleep       <= power_down_ctrl[`DCSP_BIT_SLEEP];
            o_block_off   <= next_block_off;
        end
    end

    // ****************************************
    // Two-wire slave, sampled by the system clock
    // ****************************************
    always_comb begin
        scl_rise = scl_q[1] & ~scl_d;
        scl_fall = ~scl_q[1] & scl_d;
        start    = scl_q[1] & scl_d & sda_d & ~sda_q[1];
        stop     = scl_q[1] & scl_d & ~sda_d & sda_q[1];
        rdata    = rd_reg(ptr, display_mode_reg, cathode_loop_select, cathode_level,
                          power_down_ctrl, fault_control, fault_flags);
        next_st = st;
        next_cnt = cnt;
        next_shr = shr;
        next_ptr = ptr;
        next_have_ptr = have_ptr;
        next_rd = rd;
        next_nack = nack;
        next_sda_low = sda_low;
        next_display_mode_reg = display_mode_reg;
        next_cathode_loop_select = cathode_loop_select;
        next_cathode_level = cathode_level;
        next_power_down_ctrl = power_down_ctrl;
        next_fault_control = fault_control;
        if (start) begin
            next_st = dcsp_pkg::ST_ADDR;
            next_cnt = 4'h0;
            next_sda_low = 1'b0;
        end else if (stop) begin
            next_st = dcsp_pkg::ST_IDLE;
            next_sda_low = 1'b0;
        end else begin
            unique case (st)
                dcsp_pkg::ST_IDLE: ;
                dcsp_pkg::ST_ADDR, dcsp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        next_shr = {shr[6:0], sda_q[1]};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == 4'h8) begin
                        next_st = dcsp_pkg::ST_ACK;
                        next_sda_low = 1'b1;
                        if (st == dcsp_pkg::ST_ADDR) begin
                            if (shr[7:1] == {`DCSP_SLAVE_BASE, sel_q[1]}) begin
                                next_rd = shr[0];
                                if (!shr[0]) begin
                                    next_have_ptr = 1'b0;
                                end
                            end else begin
                                next_st = dcsp_pkg::ST_IDLE;
                                next_sda_low = 1'b0;
                            end
                        end else if (!have_ptr) begin
                            next_ptr = shr;
                            next_have_ptr = 1'b1;
                        end else begin
                            next_ptr = ptr + 8'h01;
                            case (ptr)
                                `DCSP_RA_DISP_MODE: next_display_mode_reg = shr;
                                `DCSP_RA_LOOP_SEL:  next_cathode_loop_select = shr[1:0];
                                `DCSP_RA_CATH_LVL:  next_cathode_level = shr;
                                `DCSP_RA_PWR_DOWN:  next_power_down_ctrl = shr;
                                `DCSP_RA_FAULT_CTL: next_fault_control = shr;
                                default: ;
                            endcase
                        end
                    end
                end
                dcsp_pkg::ST_ACK, dcsp_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        next_nack = sda_q[1];
                    end else if (scl_fall) begin
                        if (st == dcsp_pkg::ST_MACK && nack) begin
                            next_st = dcsp_pkg::ST_IDLE;
                            next_sda_low = 1'b0;
                        end else if (rd) begin
                            next_st = dcsp_pkg::ST_TX;
                            next_shr = rdata;
                            next_ptr = ptr + 8'h01;
                            next_sda_low = ~rdata[7];
                            next_cnt = 4'h1;
                        end else begin
                            next_st = dcsp_pkg::ST_RX;
                            next_sda_low = 1'b0;
                            next_cnt = 4'h0;
                        end
                    end
                end
                dcsp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt == 4'h8) begin
                            next_st = dcsp_pkg::ST_MACK;
                            next_sda_low = 1'b0;
                        end else begin
                            next_shr = {shr[6:0], 1'b0};
                            next_sda_low = ~shr[6];
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                default: next_st = dcsp_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        scl_q <= {scl_q[0], i_scl};
        sda_q <= {sda_q[0], i_sda};
        sel_q <= {sel_q[0], i_addr_select_pin};
        scl_d <= scl_q[1];
        sda_d <= sda_q[1];
        if (i_reset) begin
            st <= dcsp_pkg::ST_IDLE;
            cnt <= 4'h0;
            shr <= 8'h00;
            ptr <= 8'h00;
            have_ptr <= 1'b0;
            rd <= 1'b0;
            nack <= 1'b0;
            sda_low <= 1'b0;
            display_mode_reg <= `DCSP_RST_DISP_MODE;
            cathode_loop_select <= `DCSP_RST_LOOP_SEL;
            cathode_level <= P_CATH_LVL_RST;
            power_down_ctrl <= `DCSP_RST_PWR_DOWN;
            fault_control <= `DCSP_RST_FAULT_CTL;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            shr <= next_shr;
            ptr <= next_ptr;
            have_ptr <= next_have_ptr;
            rd <= next_rd;
            nack <= next_nack;
            sda_low <= next_sda_low;
            display_mode_reg <= next_display_mode_reg;
            cathode_loop_select <= next_cathode_loop_select;
            cathode_level <= next_cathode_level;
            power_down_ctrl <= next_power_down_ctrl;
            fault_control <= next_fault_control;
        end
    end

    // Open-drain data only; bus clock is never driven
    assign o_sda    = 1'b0;
    assign o_sda_oe = sda_low | i_reset;

    // ****************************************
    // Checks
    // ****************************************
    property p_rst_sda;
        @(posedge i_clk_sys) i_reset |-> o_sda_oe && !o_sda;
    endproperty
    a_rst_sda: assert property (p_rst_sda) else $error("sda not low in reset");
    property p_blank;
        @(posedge i_clk_sys) disable iff (i_reset)
        fault_control[7] && (|flt_live) |=> o_array_black && fault_blank;
    endproperty
    a_blank: assert property (p_blank) else $error("fault did not blank");
    property p_unblank;
        @(posedge i_clk_sys) disable iff (i_reset)
        !fault_control[7] && !display_mode_reg[5] |=> !o_array_black;
    endproperty
    a_unblank: assert property (p_unblank) else $error("image not restored");
    property p_array_blank_bit;
        @(posedge i_clk_sys) disable iff (i_reset) display_mode_reg[5] |=> o_array_black;
    endproperty
    a_array_blank_bit: assert property (p_array_blank_bit) else $error("array not black");
    property p_flags;
        @(posedge i_clk_sys) disable iff (i_reset) !tick |=> $stable(fault_flags);
    endproperty
    a_flags: assert property (p_flags) else $error("flags changed off period");
    property p_manual;
        @(posedge i_clk_sys) disable iff (i_reset) cathode_loop_select == 2'h2 |=>
            o_cathode.manual && !o_cathode.dimming && o_cathode.target == $past(cathode_level);
    endproperty
    a_manual: assert property (p_manual) else $error("manual loop wrong");
    property p_hybrid;
        @(posedge i_clk_sys) disable iff (i_reset)
        cathode_loop_select == 2'h1 && i_auto_target < cathode_level |=> o_cathode.manual;
    endproperty
    a_hybrid: assert property (p_hybrid) else $error("hybrid did not switch");
    property p_auto;
        @(posedge i_clk_sys) disable iff (i_reset) !i_reset && cathode_loop_select == 2'h0 |=>
            !o_cathode.manual && o_cathode.target == $past(i_auto_target);
    endproperty
    a_auto: assert property (p_auto) else $error("auto loop wrong");
    property p_foreign;
        @(posedge i_clk_sys) disable iff (i_reset)
        st == dcsp_pkg::ST_ADDR && scl_fall && cnt == 4'h8 && !start && !stop
            && shr[7:1] != {6'h17, sel_q[1]} |=> !sda_low && st == dcsp_pkg::ST_IDLE;
    endproperty
    a_foreign: assert property (p_foreign) else $error("acked foreign address");
    property p_txrel;
        @(posedge i_clk_sys) disable iff (i_reset)
        st == dcsp_pkg::ST_TX && scl_fall && cnt == 4'h8 && !start && !stop |=> !sda_low;
    endproperty
    a_txrel: assert property (p_txrel) else $error("line not released");
endmodule

// ==== dv/dcsp_host.sv ====
// Two-wire bus master model that drives the display control port
module dcsp_host (
    // Clock
    input  wire logic i_clk,
    // Bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************
    // Bus timing
    // ********************
    // High 4 clocks, low 4 clocks: 32 ns bus period, short for run time
    // Real host stays at or below 400 kHz; slave needs 4 clocks a phase
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Start or repeated start
    task automatic start();
        w(4);
        o_sda_oe <= 1'b0;
        w(4);
        o_scl <= 1'b1;
        w(4);
        o_sda_oe <= 1'b1;
        w(4);
        o_scl <= 1'b0;
    endtask

    task automatic stop();
        w(4);
        o_sda_oe <= 1'b1;
        w(4);
        o_scl <= 1'b1;
        w(4);
        o_sda_oe <= 1'b0;
        w(4);
    endtask

    // Data set mid low phase, sampled mid high phase
    task automatic bitx(input logic b, output logic r);
        w(2);
        o_sda_oe <= ~b;
        w(2);
        o_scl <= 1'b1;
        w(2);
        r = i_sda;
        w(2);
        o_scl <= 1'b0;
    endtask

    // Byte out, MSB first, then acknowledge slot
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask

    // Byte in, then master acknowledge or not
    task automatic rbyte(output logic [7:0] b, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, b[i]);
        end
        bitx(~ack, r);
    endtask
endmodule

// ==== dv/tb_display_control_serial_port.sv ====
// Self-checking bench for the display control serial port
module tb_display_control_serial_port;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************
    // Signals
    // ********************
    localparam int unsigned FLAG_CYC = 20;
    logic                    clk       = 1'b0;
    logic                    rst       = 1'b1;
    logic                    sel       = 1'b0;
    logic [5:0]              fault_raw = 6'h00;
    logic [7:0]              auto_tgt  = 8'h40;
    logic                    scl;
    logic                    host_oe;
    logic                    dut_sda;
    logic                    dut_oe;
    logic                    sda;
    logic                    fault;
    logic                    black;
    dcsp_pkg::dcsp_cathode_s cath;
    logic                    sleep;
    logic [6:0]              blk_off;
    int                      error_cnt = 0;
    int                      n_checks  = 0;

    always #2 clk = ~clk;
    // Pull-up bus: low when either side pulls
    assign sda = (dut_oe ? dut_sda : 1'b1) & ~host_oe;

    dcsp_top #(.P_FLAG_CYC(FLAG_CYC)) dut (
        .i_clk_sys(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda), .o_sda(dut_sda),
        .o_sda_oe(dut_oe), .i_addr_select_pin(sel), .i_fault_raw(fault_raw),
        .o_fault(fault), .o_array_black(black), .i_auto_target(auto_tgt),
        .o_cathode(cath), .o_sleep(sleep), .o_block_off(blk_off)
    );
    dcsp_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

    // ********************
    // Shared tasks
    // ********************
    task automatic wrap_up();
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        logic a;
        host.start();
        host.wbyte(8'h5C, a);
        host.wbyte(ra, a);
        chk(a, 1'b1);
        host.wbyte(d, a);
        chk(a, 1'b1);
        host.stop();
        repeat (8) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
        logic       a;
        logic [7:0] v;
        host.start();
        host.wbyte(8'h5C, a);
        host.wbyte(ra, a);
        host.start();
        host.wbyte(8'h5D, a);
        host.rbyte(v, 1'b0);
        host.stop();
        chk(v, exp);
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_seq();
        logic       a;
        logic [7:0] v;
        logic [7:0] wd [3] = '{8'h02, 8'h55, 8'h03};
        host.start();
        host.wbyte(8'h5C, a);
        host.wbyte(8'h0C, a);
        for (int i = 0; i < 3; i++) begin
            host.wbyte(wd[i], a);
            chk(a, 1'b1);
        end
        host.stop();
        repeat (8) @(posedge clk);
        chk(16'(cath), 16'h0156);
        chk(sleep, 1'b1);
        chk(blk_off, 7'h7F);
        host.start();
        host.wbyte(8'h5C, a);
        host.wbyte(8'h0C, a);
        host.start();
        host.wbyte(8'h5D, a);
        for (int i = 0; i < 3; i++) begin
            host.rbyte(v, i < 2);
            chk(v, wd[i]);
        end
        host.stop();
        wr(8'h0E, 8'h04);
        chk(sleep, 1'b0);
        chk(blk_off, 7'h02);
    endtask

    task automatic t_loop();
        wr(8'h0C, 8'h01);
        chk(16'(cath), 16'h0157);
        @(posedge clk) auto_tgt <= 8'h60;
        repeat (4) @(posedge clk);
        chk(16'(cath), 16'h0181);
        wr(8'h0C, 8'h00);
        @(posedge clk) auto_tgt <= 8'h40;
        repeat (4) @(posedge clk);
        chk(16'(cath), 16'h0101);
    endtask

    task automatic t_addr();
        logic a;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 2; k++) begin
                @(posedge clk) sel <= s[0];
                repeat (8) @(posedge clk);
                host.start();
                host.wbyte({6'h17, k[0], 1'b0}, a);
                host.stop();
                chk(a, k == s);
            end
        end
        @(posedge clk) sel <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic t_fault();
        wr(8'h1E, 8'h3F);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) fault_raw <= 6'(1 << i);
            repeat (3 * FLAG_CYC) @(posedge clk);
            chk(fault, 1'b1);
            rd(8'h1F, 8'(1 << i));
        end
        wr(8'h1F, 8'h00);
        rd(8'h1F, 8'h20);
        wr(8'h1E, 8'h1F);
        chk(fault, 1'b0);
        wr(8'h02, 8'h00);
        chk(black, 1'b0);
        wr(8'h1E, 8'hBF);
        chk(black, 1'b1);
        wr(8'h1E, 8'h3F);
        chk(black, 1'b0);
        @(posedge clk) fault_raw <= 6'h00;
    endtask

    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (10) @(posedge clk);
        #1 chk(dut_oe, 1'b1);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk(black, 1'b1);
        rd(8'h02, 8'h20);
        rd(8'h0D, 8'h80);
        rd(8'h1E, 8'h00);
        t_seq();
        t_loop();
        t_addr();
        t_fault();
        wrap_up();
    end

    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule
